/* vfdsc_top.sv */
// shutdown sequencing, user font, cursor and indicator blink control
// Summary of operation
// - config bit 0: one runs, zero shuts down
// - registers writable in shutdown; test overrides it
// - oscillator stops after current 100us period
// - tube driver blanked throughout shutdown
// - shutdown leaves all register contents intact
// - square-wave pump output low during shutdown
// - filament phase outputs low during shutdown
// - blank whole first multiplex cycle after exit
// - 7-segment: byte0 bits 6..0 drive a..g
// - 14/16-segment: byte1 drives g2,h,i,j,k,l,m
// - byte0 drives a..g1; 16-seg uses a1,d2
// - writing 0x80 sets pointer lowest; reset value
// - writing 0xAF sets pointer to entry 47
// - pointer values 0xB0..0xFF reset to lowest
// - font read returns byte with bit7 clear
// - cursor bit7: steady or first-half blink
// - cursor row, digit; bits 6,5 set: none
// - indicator byte holds four 2-bit fields
// - field: off, first half, second half, steady
// - config layout P,M,R,T,F,B,L,S
// - lock blocks shift-limit, grids, map data writes
// - blink rate: 1s or 0.5s per half
// - clear bit erases segment and indicator data
// - config read reports current blink phase
`timescale 1ns/100ps
`default_nettype none
`include "vfdsc_defines.svh"

module vfdsc_top #(
  parameter int MUX_PERIOD_CYC = `VFDSC_MUX_PERIOD_CYC,
  parameter int BLINK_SLOW_PER = `VFDSC_BLINK_SLOW_PER,
  parameter int BLINK_FAST_PER = `VFDSC_BLINK_FAST_PER
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire vfdsc_pkg::vfdsc_req_t  regReq,
  output logic [7:0]              regRdData,
  input  wire logic               displayTest,
  input  wire logic               pumpSquareMode,
  input  wire logic               pumpWave,
  input  wire logic [1:0]         filamentMode,
  input  wire logic [1:0]         filamentWave,
  input  wire vfdsc_pkg::vfdsc_scan_t scan,
  output logic                    tubeDriverBlank,
  output logic                    multiplexTick,
  output logic                    pumpOut,
  output logic [1:0]              filamentOut,
  output logic                    cursorLit,
  output logic [3:0]              indicatorLit,
  output logic [13:0]             glyphSegments,
  output logic                    digitClear,
  output logic                    mapDataWrite,
  output logic [7:0]              mapDataOut,
  output logic [7:0]              gridCount,
  output logic [7:0]              shiftLimit
);
  import vfdsc_pkg::*;

  // every bit of state lives in this one record
  typedef struct packed {
    vfdsc_state_t   state;      // shutdown sequencer
    logic [15:0]    muxCnt;     // cycles into current multiplex period
    logic [15:0]    blinkCnt;   // multiplex periods into blink half
    logic           phase;      // blink phase, set in second half
    logic [7:0]     cfg;        // configuration, bit 7 unused
    logic [7:0]     cursor;     // cursor position and blink
    logic [7:0]     annun;      // four indicator fields
    logic [7:0]     grids;      // grid count
    logic [7:0]     shiftLim;   // shift limit
    logic [5:0]     fontPtr;    // glyph byte index 0..47
    logic           fontDone;   // last entry already used
    logic [47:0][6:0] glyphRam; // 24 glyphs of two bytes
    logic [7:0]     rdData;     // read answer
    logic           blank;      // tube driver blank
    logic           tick;       // end of multiplex period
    logic           pump;       // pump pin
    logic [1:0]     fil;        // filament pins
    logic           curLit;     // cursor segment
    logic [3:0]     indLit;     // indicator segments
    logic [13:0]    segs;       // user glyph segments
    logic           clr;        // digit clear pulse
    logic           mapWr;      // map data write pulse
    logic [7:0]     mapData;    // map data byte
  } vfdsc_st_t;

  vfdsc_st_t st_q;              // registered state
  vfdsc_st_t st_d;              // next state

  // parameters meeting narrow counters are cut on purpose
  localparam logic [15:0] MUX_LAST  = 16'(MUX_PERIOD_CYC - 1);
  localparam logic [15:0] SLOW_LAST = 16'(BLINK_SLOW_PER - 1);
  localparam logic [15:0] FAST_LAST = 16'(BLINK_FAST_PER - 1);

  // all next-state logic
  always_comb begin
    logic       runReq;     // display wanted running
    logic       periodEnd;  // last cycle of multiplex period
    logic       oscOn;      // oscillator running
    logic       outLow;     // force pump and filament low
    logic [15:0] halfLast;  // last period of a blink half
    logic       syncReq;    // blink and scan restart
    logic [6:0] byte0;      // first glyph byte
    logic [6:0] byte1;      // second glyph byte
    logic       curHere;    // cursor sits on scanned digit
    logic       wrHit;      // write strobe
    logic       rdHit;      // read strobe
    logic       fontAcc;    // font data access

    st_d          = st_q;
    runReq        = 1'b0;
    periodEnd     = 1'b0;
    oscOn         = 1'b0;
    outLow        = 1'b0;
    halfLast      = 16'h0000;
    syncReq       = 1'b0;
    byte0         = 7'h00;
    byte1         = 7'h00;
    curHere       = 1'b0;
    wrHit         = regReq.wr;
    rdHit         = regReq.rd;
    fontAcc       = 1'b0;
    st_d.tick     = 1'b0;
    st_d.clr      = 1'b0;
    st_d.mapWr    = 1'b0;

    // display test keeps the display running regardless
    runReq = st_q.cfg[`VFDSC_CFG_RUN] | displayTest;

    // register writes are taken in every state
    if (wrHit) begin
      case (regReq.addr)
        `VFDSC_ADDR_CONFIG: begin
          // phase bit is read-only, clear bit self-clears
          st_d.cfg = {1'b0, regReq.data[6], 1'b0,
                      regReq.data[4:0]};
          if (regReq.data[`VFDSC_CFG_CLEAR]) begin
            st_d.clr   = 1'b1;
            st_d.annun = `VFDSC_ANNUN_RST;
          end
          syncReq = regReq.data[`VFDSC_CFG_SYNC];
        end
        `VFDSC_ADDR_CURSOR: begin
          st_d.cursor = regReq.data;
        end
        `VFDSC_ADDR_ANNUN: begin
          st_d.annun = regReq.data;
        end
        `VFDSC_ADDR_GRIDS: begin
          if (!st_q.cfg[`VFDSC_CFG_LOCK]) begin
            st_d.grids = regReq.data;
          end
        end
        `VFDSC_ADDR_SHIFTLIM: begin
          if (!st_q.cfg[`VFDSC_CFG_LOCK]) begin
            st_d.shiftLim = regReq.data;
          end
        end
        `VFDSC_ADDR_MAPDATA: begin
          if (!st_q.cfg[`VFDSC_CFG_LOCK]) begin
            st_d.mapWr   = 1'b1;
            st_d.mapData = regReq.data;
          end
        end
        `VFDSC_ADDR_FONT: begin
          if (regReq.data[`VFDSC_FONT_CMD_BIT]) begin
            // pointer command; out of range falls back to lowest
            if (regReq.data <= `VFDSC_FONT_PTR_MAX) begin
              st_d.fontPtr = regReq.data[5:0];
            end else begin
              st_d.fontPtr = 6'd0;
            end
            st_d.fontDone = 1'b0;
          end else begin
            fontAcc = 1'b1;
            if (!st_q.fontDone) begin
              st_d.glyphRam[st_q.fontPtr] = regReq.data[6:0];
            end
          end
        end
        default: begin
          // unmapped write is dropped
        end
      endcase
    end

    // register reads answer on the next edge
    if (rdHit) begin
      case (regReq.addr)
        `VFDSC_ADDR_CONFIG: begin
          st_d.rdData = {st_q.phase, st_q.cfg[6:0]};
        end
        `VFDSC_ADDR_CURSOR:   st_d.rdData = st_q.cursor;
        `VFDSC_ADDR_ANNUN:    st_d.rdData = st_q.annun;
        `VFDSC_ADDR_GRIDS:    st_d.rdData = st_q.grids;
        `VFDSC_ADDR_SHIFTLIM: st_d.rdData = st_q.shiftLim;
        `VFDSC_ADDR_MAPDATA:  st_d.rdData = st_q.mapData;
        `VFDSC_ADDR_FONT: begin
          st_d.rdData = {1'b0, st_q.glyphRam[st_q.fontPtr]};
          fontAcc     = ~wrHit;
        end
        default: st_d.rdData = 8'h00;
      endcase
    end

    // pointer steps after each data access unless a read comes with a write, stopping at the last
    if (fontAcc && !st_q.fontDone) begin
      if (st_q.fontPtr == `VFDSC_FONT_LAST) begin
        st_d.fontDone = 1'b1;
      end else begin
        st_d.fontPtr = st_q.fontPtr + 6'd1;
      end
    end

    // multiplex period timing; oscillator idle only when halted
    oscOn     = (st_q.state != VFDSC_HALT);
    periodEnd = oscOn && (st_q.muxCnt == MUX_LAST);
    if (syncReq || !oscOn || periodEnd) begin
      st_d.muxCnt = 16'h0000;
    end else begin
      st_d.muxCnt = st_q.muxCnt + 16'h0001;
    end
    st_d.tick = periodEnd && !syncReq;

    // shutdown sequencer
    case (st_q.state)
      VFDSC_RUN: begin
        // a request landing on a period end has no period left to
        // finish, so halting at once avoids one needless extra period
        if (!runReq) begin
          st_d.state = periodEnd ? VFDSC_HALT : VFDSC_DRAIN;
        end
      end
      VFDSC_DRAIN: begin
        // finish the period in progress before halting
        if (periodEnd) st_d.state = VFDSC_HALT;
      end
      VFDSC_HALT: begin
        if (runReq) st_d.state = VFDSC_FLUSH;
      end
      VFDSC_FLUSH: begin
        // driver contents are stale for one whole cycle
        if (!runReq) begin
          st_d.state = periodEnd ? VFDSC_HALT : VFDSC_DRAIN;
        end else if (periodEnd) begin
          st_d.state = VFDSC_RUN;
        end
      end
      default: st_d.state = VFDSC_HALT;
    endcase

    // blank in every state but normal running
    st_d.blank = (st_d.state != VFDSC_RUN);

    // waveforms forced low only while actually shut down
    outLow = (st_d.state == VFDSC_DRAIN) ||
             (st_d.state == VFDSC_HALT);
    st_d.pump = pumpWave & ~(pumpSquareMode & outLow);
    for (int i = 0; i < 2; i++) begin
      st_d.fil[i] = filamentWave[i] & ~(filamentMode[i] & outLow);
    end

    // one blink phase for cursor and indicators
    halfLast = st_q.cfg[`VFDSC_CFG_FAST] ? FAST_LAST : SLOW_LAST;
    if (syncReq) begin
      st_d.blinkCnt = 16'h0000;
      st_d.phase    = 1'b0;
    end else if (periodEnd) begin
      if (st_q.blinkCnt >= halfLast) begin
        st_d.blinkCnt = 16'h0000;
        st_d.phase    = ~st_q.phase;
      end else begin
        st_d.blinkCnt = st_q.blinkCnt + 16'h0001;
      end
    end

    // cursor: hidden when bits 6 and 5 are both set
    curHere = (st_q.cursor[`VFDSC_CUR_ROW] == scan.row) &&
              (st_q.cursor[5:0] == scan.digit) &&
              !(st_q.cursor[`VFDSC_CUR_ROW] &&
                st_q.cursor[`VFDSC_CUR_OFF_HI]);
    st_d.curLit = curHere &&
                  (!st_q.cursor[`VFDSC_CUR_BLINK] || !st_q.phase);

    // indicator fields decoded against the shared phase
    for (int i = 0; i < 4; i++) begin
      case (st_q.annun[2*i +: 2])
        2'b00:   st_d.indLit[i] = 1'b0;
        2'b01:   st_d.indLit[i] = ~st_q.phase;
        2'b10:   st_d.indLit[i] = st_q.phase;
        default: st_d.indLit[i] = 1'b1;
      endcase
    end

    // user glyph segments; upper 7 bits a/a1..g/g1
    byte0 = st_q.glyphRam[{scan.glyph, 1'b0}];
    byte1 = st_q.glyphRam[{scan.glyph, 1'b1}];
    case (scan.kind)
      VFDSC_SEG7:  st_d.segs = {byte0, 7'h00};
      VFDSC_SEG14: st_d.segs = {byte0, byte1};
      VFDSC_SEG16: st_d.segs = {byte0, byte1};
      default:     st_d.segs = 14'h0000;
    endcase
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q          <= '0;
      st_q.state    <= VFDSC_HALT;
      st_q.cfg      <= `VFDSC_CONFIG_RST;
      st_q.cursor   <= `VFDSC_CURSOR_RST;
      st_q.annun    <= `VFDSC_ANNUN_RST;
      st_q.grids    <= `VFDSC_GRIDS_RST;
      st_q.shiftLim <= `VFDSC_SHIFTLIM_RST;
      st_q.fontPtr  <= 6'd0;
      st_q.blank    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state record
  assign regRdData       = st_q.rdData;
  assign tubeDriverBlank = st_q.blank;
  assign multiplexTick   = st_q.tick;
  assign pumpOut         = st_q.pump;
  assign filamentOut     = st_q.fil;
  assign cursorLit       = st_q.curLit;
  assign indicatorLit    = st_q.indLit;
  assign glyphSegments   = st_q.segs;
  assign digitClear      = st_q.clr;
  assign mapDataWrite    = st_q.mapWr;
  assign mapDataOut      = st_q.mapData;
  assign gridCount       = st_q.grids;
  assign shiftLimit      = st_q.shiftLim;

endmodule : vfdsc_top
`default_nettype wire

/* vfdsc_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef VFDSC_DEFINES_SVH
`define VFDSC_DEFINES_SVH

// register offsets
`define VFDSC_ADDR_GRIDS     8'h03
`define VFDSC_ADDR_CONFIG    8'h04
`define VFDSC_ADDR_FONT      8'h05
`define VFDSC_ADDR_MAPDATA   8'h06
`define VFDSC_ADDR_SHIFTLIM  8'h0E
`define VFDSC_ADDR_CURSOR    8'h0F
`define VFDSC_ADDR_ANNUN     8'h10

// configuration register fields
`define VFDSC_CFG_RUN        0
`define VFDSC_CFG_LOCK       1
`define VFDSC_CFG_FAST       2
`define VFDSC_CFG_FONT16     3
`define VFDSC_CFG_SYNC       4
`define VFDSC_CFG_CLEAR      5
`define VFDSC_CFG_MODE       6
`define VFDSC_CFG_PHASE      7

// cursor register fields
`define VFDSC_CUR_BLINK      7
`define VFDSC_CUR_ROW        6
`define VFDSC_CUR_OFF_HI     5

// font pointer command values
`define VFDSC_FONT_CMD_BIT   7
`define VFDSC_FONT_PTR_MIN   8'h80
`define VFDSC_FONT_PTR_MAX   8'hAF
`define VFDSC_FONT_LAST      6'd47

// reset values
`define VFDSC_CONFIG_RST     8'h00
`define VFDSC_CURSOR_RST     8'h60
`define VFDSC_ANNUN_RST      8'h00
`define VFDSC_GRIDS_RST      8'h00
`define VFDSC_SHIFTLIM_RST   8'h00

// timing
`define VFDSC_CLK_PERIOD_NS  20
`define VFDSC_MUX_PERIOD_NS  100000
`define VFDSC_MUX_PERIOD_CYC (`VFDSC_MUX_PERIOD_NS / `VFDSC_CLK_PERIOD_NS)
`define VFDSC_BLINK_SLOW_MS  1000
`define VFDSC_BLINK_FAST_MS  500
`define VFDSC_BLINK_SLOW_PER \
  (`VFDSC_BLINK_SLOW_MS * 1000000 / `VFDSC_MUX_PERIOD_NS)
`define VFDSC_BLINK_FAST_PER \
  (`VFDSC_BLINK_FAST_MS * 1000000 / `VFDSC_MUX_PERIOD_NS)

`endif

/* vfdsc_pkg.sv */
// types shared by the display control block
package vfdsc_pkg;

  // register access from the serial front end
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [7:0] addr;  // register address
    logic [7:0] data;  // write data
  } vfdsc_req_t;

  // digit currently being scanned
  typedef enum logic [1:0] {
    VFDSC_SEG7  = 2'b00,
    VFDSC_SEG14 = 2'b01,
    VFDSC_SEG16 = 2'b10
  } vfdsc_digit_t;

  typedef struct packed {
    logic         row;    // second row when set
    logic [5:0]   digit;  // digit 0..47
    logic [4:0]   glyph;  // user glyph slot 0..23
    vfdsc_digit_t kind;   // segment count of the digit
  } vfdsc_scan_t;

  // shutdown sequencer states
  typedef enum logic [3:0] {
    VFDSC_RUN   = 4'b0001,
    VFDSC_DRAIN = 4'b0010,
    VFDSC_HALT  = 4'b0100,
    VFDSC_FLUSH = 4'b1000
  } vfdsc_state_t;

endpackage : vfdsc_pkg

/* vfdsc_top_asserts.sv */
// concurrent checks on the ports of the display control block
`timescale 1ns/100ps
`default_nettype none
`include "vfdsc_defines.svh"

module vfdsc_top_asserts #(
  parameter int MUX_PERIOD_CYC = `VFDSC_MUX_PERIOD_CYC // period cycles
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire vfdsc_pkg::vfdsc_req_t  regReq,
  input wire logic [7:0]             regRdData,
  input wire logic                   displayTest,
  input wire logic                   pumpSquareMode,
  input wire logic [1:0]             filamentMode,
  input wire vfdsc_pkg::vfdsc_scan_t scan,
  input wire logic                   tubeDriverBlank,
  input wire logic                   pumpOut,
  input wire logic [1:0]             filamentOut,
  input wire logic                   cursorLit,
  input wire logic [3:0]             indicatorLit,
  input wire logic [13:0]            glyphSegments,
  input wire logic                   digitClear,
  input wire logic                   mapDataWrite,
  input wire logic [7:0]             gridCount
);
  import vfdsc_pkg::*;

  logic [7:0]  curQ;     // shadow of the cursor byte
  logic [7:0]  annQ;     // shadow of the indicator byte
  logic        lockQ;    // shadow of the lock bit
  logic [15:0] blankRun; // consecutive blanked cycles
  logic [3:0]  onM;      // indicator fields that are steady on
  logic [3:0]  fixM;     // indicator fields that do not blink
  wire logic   cfgWr = regReq.wr && regReq.addr == `VFDSC_ADDR_CONFIG;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  // shadows follow host writes so checks need no internal probes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      curQ     <= 8'h60;
      annQ     <= 8'h00;
      lockQ    <= 1'b0;
      blankRun <= 16'h0000;
    end else begin
      blankRun <= tubeDriverBlank ? blankRun + 16'h0001 : 16'h0000;
      if (cfgWr)
        lockQ <= regReq.data[1];
      if (regReq.wr && regReq.addr == `VFDSC_ADDR_CURSOR)
        curQ <= regReq.data;
      if (regReq.wr && regReq.addr == `VFDSC_ADDR_ANNUN)
        annQ <= regReq.data;
      if (cfgWr && regReq.data[5])
        annQ <= 8'h00; // clear wins, both cannot hit one cycle anyway
    end
  end

  // equal bits in a field mean off or steady, no blink dependence
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      onM[i]  = &annQ[2*i +: 2];
      fixM[i] = ~^annQ[2*i +: 2];
    end
  end

  AST_SHUT_BLANK: assert property (
    cfgWr && !regReq.data[0] && !displayTest |-> ##2 tubeDriverBlank)
    else $error("blank not raised after shutdown");
  AST_SHUT_DRIVES: assert property (
    cfgWr && !regReq.data[0] && !displayTest |-> ##2
    (!(pumpOut && pumpSquareMode) && (filamentOut & filamentMode) == 2'b00))
    else $error("pump or filament active in shutdown");
  AST_EXIT_BLANK: assert property (
    $fell(tubeDriverBlank) |-> blankRun >= 16'(MUX_PERIOD_CYC))
    else $error("blank released before a full period");
  AST_FONT_READ: assert property (
    regReq.rd && regReq.addr == `VFDSC_ADDR_FONT |=> !regRdData[7])
    else $error("font read with top bit set");
  AST_LOCK_GRIDS: assert property (
    regReq.wr && regReq.addr == `VFDSC_ADDR_GRIDS && lockQ
    |=> $stable(gridCount))
    else $error("grid count changed while locked");
  AST_LOCK_MAP: assert property (
    regReq.wr && regReq.addr == `VFDSC_ADDR_MAPDATA && lockQ
    |=> !mapDataWrite)
    else $error("map data written while locked");
  AST_GRIDS_WRITE: assert property (
    regReq.wr && regReq.addr == `VFDSC_ADDR_GRIDS && !lockQ
    |=> gridCount == $past(regReq.data))
    else $error("grid count write lost while unlocked");
  AST_SEG7_BYTE1: assert property (
    scan.kind == VFDSC_SEG7 |=> glyphSegments[6:0] == 7'h00)
    else $error("second glyph byte shown on 7-segment digit");
  AST_CLEAR: assert property (
    cfgWr && regReq.data[5] |-> ##[1:2] digitClear)
    else $error("clear bit gave no clear pulse");
  AST_NO_CURSOR: assert property (
    curQ[6:5] == 2'b11 && !displayTest |=> !cursorLit)
    else $error("cursor lit with position off");
  AST_STEADY_CURSOR: assert property (
    !tubeDriverBlank && !displayTest && !curQ[7] && curQ[6:5] != 2'b11
    && scan.row == curQ[6] && scan.digit == curQ[5:0] |=> cursorLit)
    else $error("steady cursor not lit");
  AST_INDICATOR: assert property (
    !tubeDriverBlank && !displayTest
    |=> ((indicatorLit ^ $past(onM)) & $past(fixM)) == 4'h0)
    else $error("indicator off or steady field wrong");
endmodule : vfdsc_top_asserts

bind vfdsc_top vfdsc_top_asserts #(
  .MUX_PERIOD_CYC(MUX_PERIOD_CYC)
) u_vfdsc_top_asserts (
  .clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
  .displayTest(displayTest), .scan(scan),
  .pumpSquareMode(pumpSquareMode), .filamentMode(filamentMode),
  .tubeDriverBlank(tubeDriverBlank), .pumpOut(pumpOut),
  .filamentOut(filamentOut), .cursorLit(cursorLit),
  .indicatorLit(indicatorLit), .glyphSegments(glyphSegments),
  .digitClear(digitClear), .mapDataWrite(mapDataWrite),
  .gridCount(gridCount)
);
`default_nettype wire

/* vfdsc_tube_model.sv */
// behavioural model of the downstream shift-register tube driver
`timescale 1ns/100ps
`default_nettype none

module vfdsc_tube_model (
  input  wire logic        clk,
  input  wire logic        blank,
  input  wire logic        tick,
  input  wire logic [13:0] segs,
  output logic      [13:0] lampSegs
);
  logic [13:0] latchQ; // pattern shifted in at the last boundary

  // a new pattern is taken at each multiplex boundary
  always_ff @(posedge clk) begin
    if (tick) begin
      latchQ <= segs;
    end
  end

  // blanked anodes show nothing usable, never the stale pattern
  assign lampSegs = blank ? ~latchQ : latchQ;
endmodule : vfdsc_tube_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the display control block
`timescale 1ns/100ps
`default_nettype none
`include "vfdsc_defines.svh"

module tb_top;
  import vfdsc_pkg::*;
  localparam int MP = 8; // shortened multiplex period
  localparam logic [7:0] FNT = `VFDSC_ADDR_FONT;
  localparam logic [7:0] CFG = `VFDSC_ADDR_CONFIG;
  localparam logic [7:0] GRD = `VFDSC_ADDR_GRIDS;
  localparam logic [7:0] SHL = `VFDSC_ADDR_SHIFTLIM;
  localparam logic [7:0] ANN = `VFDSC_ADDR_ANNUN;
  localparam logic [7:0] CUR = `VFDSC_ADDR_CURSOR;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  vfdsc_req_t  regReq = '0;
  logic        displayTest = 1'b0;
  logic        pumpWave = 1'b1;
  logic [1:0]  filamentWave = 2'b11;
  vfdsc_scan_t scan = '0;
  logic [7:0]  regRdData, gridCount, shiftLimit, mapDataOut;
  logic        tubeDriverBlank, multiplexTick, pumpOut, cursorLit, ph;
  logic        mapDataWrite;
  logic        pumpMode = 1'b1;   // pump runs as square wave
  logic [1:0]  filMode = 2'b11;   // both phases drive the filament
  logic [1:0]  filamentOut;
  logic [3:0]  indicatorLit;
  logic [13:0] glyphSegments, lampSegs;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          ticks = 0;
  int          tSync, k, m;

  vfdsc_top #(.MUX_PERIOD_CYC(MP), .BLINK_SLOW_PER(3), .BLINK_FAST_PER(2))
  u_vfdsc_top (
    .clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
    .displayTest(displayTest), .pumpSquareMode(pumpMode),
    .pumpWave(pumpWave),
    .filamentMode(filMode), .filamentWave(filamentWave), .scan(scan),
    .tubeDriverBlank(tubeDriverBlank), .multiplexTick(multiplexTick),
    .pumpOut(pumpOut), .filamentOut(filamentOut), .cursorLit(cursorLit),
    .indicatorLit(indicatorLit), .glyphSegments(glyphSegments),
    .digitClear(), .mapDataWrite(mapDataWrite), .mapDataOut(mapDataOut),
    .gridCount(gridCount), .shiftLimit(shiftLimit));

  vfdsc_tube_model u_vfdsc_tube_model (.clk(clk), .blank(tubeDriverBlank),
    .tick(multiplexTick), .segs(glyphSegments), .lampSegs(lampSegs));

  always #10 clk = ~clk;

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // one-cycle write strobe, inputs change on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq.wr = 1'b1;
    regReq.addr = a;
    regReq.data = d;
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask : wr

  // answer is registered, so look one full cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regReq.rd = 1'b1;
    regReq.addr = a;
    @(negedge clk);
    regReq.rd = 1'b0;
    @(negedge clk);
    chk({8'h00, regRdData}, {8'h00, e});
  endtask : rd

  task automatic seg(input vfdsc_digit_t kd, input logic [13:0] e);
    @(negedge clk);
    scan.kind = kd;
    @(negedge clk);
    chk({2'b00, glyphSegments}, {2'b00, e});
  endtask : seg

  initial begin
    step(16);
    nrst = 1'b1;
    chk(16'(tubeDriverBlank), 16'h0001);
    // pointer must already sit at entry 0 after reset
    wr(FNT, 8'h55);
    wr(FNT, 8'h80);
    rd(FNT, 8'h55);
    wr(FNT, 8'h2A);
    wr(FNT, 8'hAF);
    wr(FNT, 8'h33);
    wr(FNT, 8'h7F);
    wr(FNT, 8'hB0);
    rd(FNT, 8'h55);
    rd(FNT, 8'h2A);
    wr(FNT, 8'hAF);
    rd(FNT, 8'h33);
    // leave shutdown: one whole period stays blanked
    wr(CFG, 8'h01);
    step(MP);
    chk(16'(tubeDriverBlank), 16'h0001);
    step(MP + 4);
    chk({12'h000, tubeDriverBlank, pumpOut, filamentOut}, 16'h0007);
    pumpWave = 1'b0;
    filamentWave = 2'b01;
    step(2);
    chk({12'h000, tubeDriverBlank, pumpOut, filamentOut}, 16'h0001);
    pumpWave = 1'b1;
    filamentWave = 2'b11;
    seg(VFDSC_SEG7, {7'h55, 7'h00});
    seg(VFDSC_SEG14, {7'h55, 7'h2A});
    seg(VFDSC_SEG16, {7'h55, 7'h2A});
    step(MP + 2);
    chk({2'b00, lampSegs}, {2'b00, 7'h55, 7'h2A});
    wr(GRD, 8'h0A);
    // enter shutdown while running
    wr(CFG, 8'h00);
    step(2);
    chk({12'h000, tubeDriverBlank, pumpOut, filamentOut}, 16'h0008);
    for (k = 0; k < 3 * MP; k++) begin
      @(negedge clk);
      ticks += int'(multiplexTick);
    end
    chk(16'(ticks <= 1), 16'h0001);
    // outputs not configured as pump or filament keep their wave
    pumpMode = 1'b0;
    filMode = 2'b10;
    step(2);
    chk({12'h000, tubeDriverBlank, pumpOut, filamentOut}, 16'h000D);
    pumpMode = 1'b1;
    filMode = 2'b11;
    wr(SHL, 8'h21);
    step(1);
    chk({8'h00, shiftLimit}, 16'h0021);
    rd(GRD, 8'h0A);
    wr(ANN, 8'hE4);
    wr(CFG, 8'h20);
    rd(ANN, 8'h00);
    // test mode keeps the tube running through shutdown
    displayTest = 1'b1;
    step(2 * MP + 4);
    chk(16'(tubeDriverBlank), 16'h0000);
    displayTest = 1'b0;
    step(4);
    chk(16'(tubeDriverBlank), 16'h0001);
    wr(CFG, 8'h03);
    wr(GRD, 8'h55);
    rd(GRD, 8'h0A);
    wr(SHL, 8'h44);
    step(1);
    chk({8'h00, shiftLimit}, 16'h0021);
    wr(`VFDSC_ADDR_MAPDATA, 8'h12);
    chk({7'h00, mapDataWrite, mapDataOut}, 16'h0000);
    wr(CFG, 8'h01);
    wr(`VFDSC_ADDR_MAPDATA, 8'h34);
    chk({7'h00, mapDataWrite, mapDataOut}, 16'h0134);
    rd(`VFDSC_ADDR_MAPDATA, 8'h34);
    wr(GRD, 8'h0C);
    step(1);
    chk({8'h00, gridCount}, 16'h000C);
    // blinking: field 01 first half, 10 second half, 11 steady
    wr(ANN, 8'hE4);
    wr(CUR, 8'h85);
    scan.digit = 6'd5;
    step(2 * MP);
    wr(CFG, 8'h15);
    tSync = cyc;
    rd(CFG, 8'h15);
    step(14);
    rd(CFG, 8'h95);
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      m = (cyc - tSync) % (2 * MP);
      ph = 1'(((cyc - tSync) / (2 * MP)) % 2);
      if (m > 3 && m < 2 * MP - 3) begin
        chk({11'h000, cursorLit, indicatorLit},
            {11'h000, ~ph, 1'b1, ph, ~ph, 1'b0});
      end
    end
    wr(CUR, 8'h05);
    step(2);
    chk(16'(cursorLit), 16'h0001);
    wr(CUR, 8'h65);
    step(2);
    chk(16'(cursorLit), 16'h0000);
    rd(8'h7F, 8'h00);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
